/* verilog/adc_os_defs.svh */
// register map, field positions, reset values and timing counts
`ifndef ADC_OS_DEFS_SVH
`define ADC_OS_DEFS_SVH
`define OFF_SCAN_CTRL 8'h00
`define OFF_CLK_CTRL 8'h04
`define OFF_FILT_SET 8'h08
`define OFF_CHAN_CTRL 8'h0c
`define OFF_GRP_STATE 8'h10
`define OFF_CONV_STATE 8'h14
`define OFF_RESULT0 8'h18
`define OFF_RESULT1 8'h1c
`define OFF_RESULT2 8'h20
`define OFF_RESULT3 8'h24
`define OFF_FIFO_RES 8'h28
`define F_SW_TRIG 0
`define F_STOP 1
`define F_SW_GRP 2
`define F_FIFO_EN 3
`define F_IRQ_EN 4
`define F_MODE 6:5
`define F_AVG 8:7
`define F_SAMP 11:9
`define F_MASK0 15:12
`define F_MASK1 19:16
`define RST_SCAN_CTRL 20'h00600
`define MODE_BG 2'h0
`define MODE_CONT 2'h1
`define MODE_SINGLE 2'h2
`define MODE_OS 2'h3
`define TAPS 22
`define FILL_FULL 5'h16
`define SAR_TICKS 3'h5
`define GD_SINC 11
`define GD_MINPH 2
`endif

/* verilog/adc_os_pkg.sv */
// types shared by the oversampling scan controller
`include "adc_os_defs.svh"
package adc_os_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10
    } phase_e;
    typedef logic [3:0][`TAPS-1:0][11:0] taps_t;
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } ahb_req_s;
    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } ahb_rsp_s;
    typedef struct packed {
        ahb_rsp_s rsp;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [19:0] ctrl;
        logic [3:0] div;
        logic [3:0] ftype;
        logic [15:0] chcfg;
        logic [1:0] gact;
        logic cact;
        logic grp;
        phase_e phase;
        logic [3:0] divcnt;
        logic tick;
        logic [2:0] pcnt;
        logic [1:0] chan;
        taps_t taps;
        logic [3:0][4:0] fill;
        logic [3:0][19:0] acc;
        logic [3:0][2:0] acnt;
        logic [3:0][15:0] latest;
        logic [3:0] lvalid;
        logic [3:0] done;
        logic [3:0][15:0] result;
        logic [17:0] fifo;
        logic irq;
        logic sample;
    } st_s;
endpackage

/* verilog/adc_oversample_filter_scan.sv */
// oversampling scan and decimating filter controller with ahb-lite regs
//
// Contract
// - a software or peripheral trigger starts only its own scan group
// - scan start sets group active flag and converter active flag
// - hybrid modes move to the next channel after every oversample
// - first result only after all taps filled plus averaging time
// - later rounds keep taps; results follow after group delay
// - start trigger in background copies latest results to registers
// - after such a copy the scan-end interrupt fires if enabled
// - background rounds repeat until a conversion stop
// - four filters per converter, 22 taps each
// - sinc or minimum phase chosen by channel select and setting reg
// - conversion values shift in; output only once taps are full
// - oversampling mode clears taps once a result or average is done
// - hybrid filters up to four channels in parallel
// - hybrid single scan clears all taps at scan end
// - continuous and background keep taps, new result each oversample
// - forced stop clears the taps of the filters involved
// - background filtering runs regardless of start triggers
// - initial delay 22; group delay 11 sinc, 2 minimum phase
// - oversample is sampling time then 5 conversion clocks
// - scan completion clears both active flags, converter idles
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module adc_oversample_filter_scan (
    input wire logic clk_sys, // system clock
    input wire logic reset_n, // sync reset, low active
    input wire adc_os_pkg::ahb_req_s ahb_in, // ahb-lite request
    output adc_os_pkg::ahb_rsp_s ahb_out, // ahb-lite response
    input wire logic [1:0] periph_trig, // per-group trigger pulse
    input wire logic [11:0] conv_data, // core conversion value
    output logic conv_sample, // core sampling phase
    output logic [1:0] conv_channel, // channel under conversion
    output logic scan_end_irq // scan end pulse
);
    import adc_os_pkg::*;

    st_s st;
    st_s n;
    logic start_s;
    logic stop_s;
    logic capture_s;
    logic newres_s;
    logic conv_end_s;
    logic single_end_s;

    // ************************************************
    // decode helpers
    // ************************************************
    function automatic logic [1:0] next_chan(input logic [3:0] m,
                                             input logic [1:0] c);
        logic [1:0] r;
        logic f;
        r = c;
        f = 1'b0;
        for (int i = 1; i <= 4; i++) begin
            if (!f && m[2'(int'(c) + i)]) begin
                r = 2'(int'(c) + i);
                f = 1'b1;
            end
        end
        return r;
    endfunction

    function automatic logic [3:0] grp_mask(input logic [19:0] ctl,
                                            input logic g);
        return g ? ctl[`F_MASK1] : ctl[`F_MASK0];
    endfunction

    function automatic logic [2:0] fsel(input logic [15:0] cfg,
                                        input logic [1:0] c);
        return cfg[4 * c +: 3];
    endfunction

    function automatic logic filt_on(input logic [2:0] s);
        return (s != 3'h0) && (s <= 3'h4);
    endfunction

    // weights: type 0 symmetric sinc, type 1 front-loaded minimum phase
    function automatic logic [15:0] fir(input logic [`TAPS-1:0][11:0] t,
                                        input logic typ);
        logic [19:0] a;
        logic [4:0] w;
        a = '0;
        for (int i = 0; i < `TAPS; i++) begin
            if (typ) begin
                w = 5'(`TAPS - i);
            end else begin
                w = 5'((i < `TAPS / 2) ? i + 1 : `TAPS - i);
            end
            a = a + 20'(t[i] * w);
        end
        return a[19:4];
    endfunction

    function automatic logic [15:0] fmt(input logic [15:0] v,
                                        input logic f16);
        return f16 ? v : {v[15:4], 4'h0};
    endfunction

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        logic addr_ok;
        logic sw_trig;
        logic sw_grp;
        logic tg;
        logic hit;
        logic fv;
        logic [1:0] c;
        logic [1:0] md;
        logic [2:0] fs;
        logic [3:0] mask;
        logic [`TAPS-1:0][11:0] nt;
        logic [15:0] f;
        logic [15:0] res;
        logic [19:0] sum;
        logic [31:0] rd;
        n = st;
        addr_ok = 1'b0;
        sw_trig = 1'b0;
        sw_grp = 1'b0;
        tg = 1'b0;
        hit = 1'b0;
        fv = 1'b0;
        c = st.chan;
        md = st.ctrl[`F_MODE];
        fs = 3'h0;
        mask = grp_mask(st.ctrl, st.grp);
        nt = '0;
        f = '0;
        res = '0;
        sum = '0;
        rd = '0;
        start_s = 1'b0;
        stop_s = 1'b0;
        capture_s = 1'b0;
        newres_s = 1'b0;
        conv_end_s = 1'b0;
        single_end_s = 1'b0;
        n.irq = 1'b0;
        n.tick = 1'b0;
        n.rsp.hreadyout = 1'b1;
        n.rsp.hresp = 1'b0;

        // ahb-lite slave, zero wait states
        addr_ok = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;
        n.wr_pend = addr_ok && ahb_in.hwrite;
        n.wr_addr = ahb_in.haddr[7:0];
        if (ahb_in.haddr[31:8] == 24'h0) begin
            case (ahb_in.haddr[7:0])
                `OFF_SCAN_CTRL: rd = {12'h0, st.ctrl};
                `OFF_CLK_CTRL: rd = {28'h0, st.div};
                `OFF_FILT_SET: rd = {28'h0, st.ftype};
                `OFF_CHAN_CTRL: rd = {16'h0, st.chcfg};
                `OFF_GRP_STATE: rd = {30'h0, st.gact};
                `OFF_CONV_STATE: rd = {24'h0, st.lvalid, 3'h0, st.cact};
                `OFF_RESULT0: rd = {16'h0, st.result[0]};
                `OFF_RESULT1: rd = {16'h0, st.result[1]};
                `OFF_RESULT2: rd = {16'h0, st.result[2]};
                `OFF_RESULT3: rd = {16'h0, st.result[3]};
                `OFF_FIFO_RES: rd = {14'h0, st.fifo};
                default: rd = '0;
            endcase
        end
        if (addr_ok && !ahb_in.hwrite) begin
            n.rsp.hrdata = rd;
        end
        if (st.wr_pend) begin
            case (st.wr_addr)
                `OFF_SCAN_CTRL: begin
                    n.ctrl = {ahb_in.hwdata[19:2], 2'b00};
                    sw_trig = ahb_in.hwdata[`F_SW_TRIG];
                    stop_s = ahb_in.hwdata[`F_STOP];
                    sw_grp = ahb_in.hwdata[`F_SW_GRP];
                end
                `OFF_CLK_CTRL: n.div = ahb_in.hwdata[3:0];
                `OFF_FILT_SET: n.ftype = ahb_in.hwdata[3:0];
                `OFF_CHAN_CTRL: n.chcfg = ahb_in.hwdata[15:0];
                default: n.ctrl = st.ctrl;
            endcase
        end

        // conversion clock enable from divider
        if (st.cact) begin
            if (st.divcnt == st.div) begin
                n.divcnt = 4'h0;
                n.tick = 1'b1;
            end else begin
                n.divcnt = st.divcnt + 4'h1;
            end
        end else begin
            n.divcnt = 4'h0;
        end

        // oversample: sampling time then successive approximation
        case (st.phase)
            ST_IDLE: n.sample = 1'b0;
            ST_SAMPLE: begin
                if (st.tick) begin
                    if (3'(st.pcnt + 3'h1) >= st.ctrl[`F_SAMP]) begin
                        n.phase = ST_CONVERT;
                        n.pcnt = 3'h0;
                        n.sample = 1'b0;
                    end else begin
                        n.pcnt = st.pcnt + 3'h1;
                    end
                end
            end
            ST_CONVERT: begin
                if (st.tick) begin
                    if (st.pcnt == `SAR_TICKS - 3'h1) begin
                        conv_end_s = 1'b1;
                        n.pcnt = 3'h0;
                        n.phase = ST_SAMPLE;
                        n.sample = 1'b1;
                    end else begin
                        n.pcnt = st.pcnt + 3'h1;
                    end
                end
            end
            default: n.phase = ST_IDLE;
        endcase

        // filter bank: one tap line per channel, runs every oversample
        if (conv_end_s) begin
            fs = fsel(st.chcfg, c);
            if (filt_on(fs)) begin
                nt = {st.taps[c][`TAPS-2:0], conv_data};
                n.taps[c] = nt;
                fv = (st.fill[c] >= `FILL_FULL - 5'h1);
                n.fill[c] = fv ? `FILL_FULL : st.fill[c] + 5'h1;
                f = fir(nt, st.ftype[2'(fs - 3'h1)]);
            end else begin
                fv = 1'b1;
                f = {conv_data, 4'h0};
            end
            if (fv) begin
                sum = st.acc[c] + 20'(f);
                if (st.acnt[c] == 3'((4'h1 << st.ctrl[`F_AVG]) - 4'h1)) begin
                    newres_s = 1'b1;
                    res = 16'(sum >> st.ctrl[`F_AVG]);
                    n.acc[c] = '0;
                    n.acnt[c] = 3'h0;
                end else begin
                    n.acc[c] = sum;
                    n.acnt[c] = st.acnt[c] + 3'h1;
                end
            end
            if (newres_s) begin
                n.latest[c] = fmt(res, st.chcfg[4 * c + 3]);
                n.lvalid[c] = 1'b1;
                n.done[c] = 1'b1;
                if (md == `MODE_OS) begin
                    n.taps[c] = '0;
                    n.fill[c] = 5'h0;
                end
                if (md != `MODE_BG) begin
                    n.result[c] = n.latest[c];
                    if (st.ctrl[`F_FIFO_EN]) begin
                        n.fifo = {c, n.latest[c]};
                    end
                end
            end
            if (md != `MODE_OS || newres_s) begin
                n.chan = next_chan(mask, c);
            end
            if (md != `MODE_BG && (n.done & mask) == mask) begin
                n.irq = st.ctrl[`F_IRQ_EN];
                n.done = 4'h0;
                if (md == `MODE_SINGLE) begin
                    single_end_s = 1'b1;
                    n.taps = '0;
                    n.fill = '0;
                    n.acc = '0;
                    n.acnt = '0;
                    n.gact = 2'b00;
                    n.cact = 1'b0;
                    n.phase = ST_IDLE;
                    n.sample = 1'b0;
                end
            end
        end

        // triggers: start an idle group or capture in background
        tg = sw_trig ? sw_grp : !periph_trig[0];
        hit = (sw_trig && sw_grp == st.grp) || periph_trig[st.grp];
        if (!stop_s && (sw_trig || periph_trig != 2'b00)) begin
            if (!st.cact && grp_mask(n.ctrl, tg) != 4'h0) begin
                start_s = 1'b1;
                n.gact = 2'(2'b01 << tg);
                n.cact = 1'b1;
                n.grp = tg;
                n.chan = next_chan(grp_mask(n.ctrl, tg), 2'h3);
                n.phase = ST_SAMPLE;
                n.sample = 1'b1;
                n.pcnt = 3'h0;
                n.divcnt = 4'h0;
                n.done = 4'h0;
            end else if (st.cact && hit && md == `MODE_BG) begin
                capture_s = 1'b1;
                for (int i = 0; i < 4; i++) begin
                    if (mask[i] && st.lvalid[i]) begin
                        n.result[i] = st.latest[i];
                        if (st.ctrl[`F_FIFO_EN]) begin
                            n.fifo = {2'(i), st.latest[i]};
                        end
                    end
                end
                n.irq = st.ctrl[`F_IRQ_EN];
            end
        end

        // forced stop wins over triggers, taps and active flags; a result or irq due in the same cycle still lands
        if (stop_s) begin
            n.taps = '0;
            n.fill = '0;
            n.acc = '0;
            n.acnt = '0;
            n.lvalid = 4'h0;
            n.done = 4'h0;
            n.gact = 2'b00;
            n.cact = 1'b0;
            n.phase = ST_IDLE;
            n.sample = 1'b0;
            n.pcnt = 3'h0;
        end
    end

    // ************************************************
    // state register
    // ************************************************
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st <= '0;
            st.rsp.hreadyout <= 1'b1;
            st.ctrl <= `RST_SCAN_CTRL;
        end else begin
            st <= n;
        end
    end

    assign ahb_out = st.rsp;
    assign conv_sample = st.sample;
    assign conv_channel = st.chan;
    assign scan_end_irq = st.irq;

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    chk_start_flags: assert property (
        start_s |=> st.cact && $onehot(st.gact) && st.phase == ST_SAMPLE)
        else $error("start did not raise both active flags");
    chk_start_group: assert property (
        start_s |=> st.gact[st.grp] && st.grp == $past(n.grp))
        else $error("wrong scan group started");
    chk_hybrid_step: assert property (
        (conv_end_s && st.ctrl[`F_MODE] != `MODE_OS
         && $countones(grp_mask(st.ctrl, st.grp)) > 1 && !stop_s)
        |=> st.chan != $past(st.chan))
        else $error("hybrid scan stayed on one channel");
    chk_first_result: assert property (
        (st.lvalid[0] && st.ctrl[`F_MODE] == `MODE_BG
         && filt_on(fsel(st.chcfg, 2'h0)))
        |-> st.fill[0] == `FILL_FULL)
        else $error("result before taps filled");
    chk_capture_irq: assert property (
        capture_s |=> scan_end_irq == $past(st.ctrl[`F_IRQ_EN]))
        else $error("capture interrupt mismatch");
    chk_bg_keeps: assert property (
        capture_s |=> st.cact ##1 st.cact || $past(stop_s))
        else $error("background scan ended on trigger");
    chk_os_clear: assert property (
        (newres_s && st.ctrl[`F_MODE] == `MODE_OS && !stop_s)
        |=> st.fill[$past(st.chan)] == 5'h0)
        else $error("oversampling taps kept after result");
    chk_stop_clear: assert property (
        stop_s |=> st.fill == '0 && !st.cact && st.gact == 2'b00)
        else $error("stop left taps or flags");
    chk_single_end: assert property (
        single_end_s |=> st.taps == '0 && st.phase == ST_IDLE)
        else $error("single scan end kept taps");
    chk_fill_max: assert property (
        st.fill[0] <= `FILL_FULL && st.fill[3] <= `FILL_FULL)
        else $error("tap fill count overflow");

    cov_start: cover property (start_s);
    cov_capture: cover property (capture_s ##1 scan_end_irq);
    cov_single: cover property (single_end_s);
    cov_stop_run: cover property (st.cact && stop_s);
endmodule

/* dv/adc_core_model.sv */
// behavioural converter core answering the oversampling controller
`timescale 1ns/1ps
module adc_core_model (
    input wire logic clk_sys, // system clock
    input wire logic conv_sample, // sampling phase from controller
    input wire logic [1:0] conv_channel, // channel being sampled
    input wire logic [11:0] data_base, // analog level of channel 0
    output logic [11:0] conv_data // conversion value
);
    // ****************************************
    // sample then successive approximation
    // ****************************************
    logic was_smp;
    logic [1:0] held_ch;
    logic [11:0] noise;
    initial begin
        was_smp = 1'b0;
        held_ch = 2'h0;
        noise = 12'h5a3;
        conv_data = 12'h000;
    end
    always @(posedge clk_sys) begin
        was_smp <= conv_sample;
        noise <= {noise[10:0], noise[11] ^ noise[8] ^ 1'b1};
        if (conv_sample) begin
            // value not settled while the capacitor charges
            held_ch <= conv_channel;
            conv_data <= noise;
        end else if (was_smp) begin
            // each channel sits at its own fixed level
            conv_data <= data_base + 12'(held_ch) * 12'h0aa;
        end
    end
endmodule

/* dv/tb_adc_oversample_filter_scan.sv */
// self-checking bench for the oversampling scan controller
`timescale 1ns/1ps
`include "adc_os_defs.svh"
module tb_adc_oversample_filter_scan;
    import adc_os_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    localparam int W_SINC = 132;
    localparam int W_MINPH = 253;
    logic clk_sys;
    logic reset_n;
    logic m_hsel;
    logic m_hwrite;
    logic [31:0] m_haddr;
    logic [31:0] m_hwdata;
    logic [1:0] m_htrans;
    ahb_req_s ahb_in;
    ahb_rsp_s ahb_out;
    logic [1:0] periph_trig;
    logic [11:0] conv_data;
    logic [11:0] data_base;
    logic conv_sample;
    logic [1:0] conv_channel;
    logic scan_end_irq;
    logic [31:0] rdat;
    logic [1:0] prev_ch;
    int n_errors;
    int total_checks;
    int irq_cnt;
    int mark;
    int n;
    assign ahb_in = '{hsel: m_hsel, haddr: m_haddr, htrans: m_htrans,
        hwrite: m_hwrite, hsize: 3'h2, hwdata: m_hwdata,
        hready: ahb_out.hreadyout};
    adc_oversample_filter_scan u_adc_oversample_filter_scan (
        .clk_sys(clk_sys), .reset_n(reset_n), .ahb_in(ahb_in),
        .ahb_out(ahb_out), .periph_trig(periph_trig),
        .conv_data(conv_data), .conv_sample(conv_sample),
        .conv_channel(conv_channel), .scan_end_irq(scan_end_irq));
    adc_core_model u_adc_core_model (
        .clk_sys(clk_sys), .conv_sample(conv_sample),
        .conv_channel(conv_channel), .data_base(data_base),
        .conv_data(conv_data));
    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
            input string what);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] addr,
            input logic [31:0] wd);
        @(posedge clk_sys);
        m_hsel <= 1'b1;
        m_haddr <= {24'h000000, addr};
        m_htrans <= 2'h2;
        m_hwrite <= wr;
        @(posedge clk_sys);
        while (ahb_out.hreadyout !== 1'b1) @(posedge clk_sys);
        m_hsel <= 1'b0;
        m_htrans <= 2'h0;
        m_hwdata <= wd;
        @(posedge clk_sys);
        while (ahb_out.hreadyout !== 1'b1) @(posedge clk_sys);
        rdat = ahb_out.hrdata;
    endtask
    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        bus(1'b1, addr, wd);
    endtask
    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp,
            input string what);
        bus(1'b0, addr, 32'h00000000);
        check(rdat, exp, what);
        check({31'h0, ahb_out.hresp}, 32'h0, "hresp okay");
    endtask
    task automatic wait_irq(input int bound);
        n = 0;
        while (irq_cnt == mark && n < bound) begin
            @(posedge clk_sys);
            n++;
        end
        check(32'(irq_cnt - mark), 32'h1, "scan end pulse count");
    endtask
    task automatic wait_os(input int cnt);
        repeat (cnt) @(posedge conv_sample);
    endtask
    function automatic logic [31:0] filt(input logic [11:0] c, input int w,
            input logic f16);
        logic [19:0] s;
        logic [15:0] r;
        s = 20'(int'(c) * w);
        r = s[19:4];
        if (!f16) r[3:0] = 4'h0;
        return {16'h0000, r};
    endfunction
    // ****************************************
    // clock, pulse counter, watchdog
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (scan_end_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_errors++;
        print_verdict();
    end
    // ****************************************
    // tests
    // ****************************************
    initial begin
        reset_n = 1'b0;
        m_hsel = 1'b0;
        m_hwrite = 1'b0;
        m_haddr = 32'h00000000;
        m_hwdata = 32'h00000000;
        m_htrans = 2'h0;
        periph_trig = 2'h0;
        data_base = 12'h0ab;
        n_errors = 0;
        total_checks = 0;
        irq_cnt = 0;
        mark = 0;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rd_chk(`OFF_SCAN_CTRL, 32'h00000600, "scan_ctrl reset");
        rd_chk(`OFF_GRP_STATE, 32'h00000000, "group flags idle");
        rd_chk(8'h40, 32'h00000000, "unmapped read");
        wr(`OFF_CLK_CTRL, 32'h00000001);
        wr(`OFF_FILT_SET, 32'h00000000);
        wr(`OFF_CHAN_CTRL, 32'h00000b29);
        // background scan of group0, channels 0 and 1
        mark = irq_cnt;
        wr(`OFF_SCAN_CTRL, 32'h00003619);
        rd_chk(`OFF_GRP_STATE, 32'h00000001, "group0 active");
        bus(1'b0, `OFF_CONV_STATE, 32'h00000000);
        check({31'h0, rdat[0]}, 32'h1, "converter active");
        @(posedge conv_sample);
        #1 prev_ch = conv_channel;
        repeat (4) begin
            @(posedge conv_sample);
            #1 check({30'h0, conv_channel}, {30'h0, prev_ch ^ 2'h1},
                "channel rotation");
            prev_ch = conv_channel;
        end
        rd_chk(`OFF_CONV_STATE, 32'h00000001, "no early result");
        n = 0;
        rdat = 32'h00000000;
        while (rdat[7:4] !== 4'h3 && n < 300) begin
            bus(1'b0, `OFF_CONV_STATE, 32'h00000000);
            n++;
        end
        check({28'h0, rdat[7:4]}, 32'h3, "results after fill");
        check(32'(irq_cnt - mark), 32'h0, "no pulse untriggered");
        mark = irq_cnt;
        wr(`OFF_SCAN_CTRL, 32'h00003619);
        wait_irq(50);
        rd_chk(`OFF_RESULT0, filt(12'h0ab, W_SINC, 1'b1), "res0");
        rd_chk(`OFF_RESULT1, filt(12'h155, W_SINC, 1'b0), "res1");
        rd_chk(`OFF_FIFO_RES, 32'h00010000 | filt(12'h155, W_SINC, 1'b0),
            "fifo");
        rd_chk(`OFF_GRP_STATE, 32'h00000001, "still scanning");
        data_base <= 12'h100;
        wait_os(60);
        mark = irq_cnt;
        wr(`OFF_SCAN_CTRL, 32'h00003619);
        wait_irq(50);
        rd_chk(`OFF_RESULT0, filt(12'h100, W_SINC, 1'b1), "res0 b");
        rd_chk(`OFF_RESULT1, filt(12'h1aa, W_SINC, 1'b0), "res1 b");
        wr(`OFF_SCAN_CTRL, 32'h0000361a);
        rd_chk(`OFF_GRP_STATE, 32'h00000000, "stopped group");
        rd_chk(`OFF_CONV_STATE, 32'h00000000, "stopped taps");
        // continuous scan of group1 from a peripheral trigger
        wr(`OFF_FILT_SET, 32'h0000000f);
        wr(`OFF_SCAN_CTRL, 32'h00043630);
        mark = irq_cnt;
        @(posedge clk_sys);
        periph_trig <= 2'h2;
        @(posedge clk_sys);
        periph_trig <= 2'h0;
        rd_chk(`OFF_GRP_STATE, 32'h00000002, "group1 only");
        wait_irq(3000);
        rd_chk(`OFF_RESULT2, filt(12'h254, W_MINPH, 1'b1), "res2");
        check({30'h0, conv_channel}, 32'h2, "group1 channel");
        mark = irq_cnt;
        wait_irq(40);
        wr(`OFF_SCAN_CTRL, 32'h00043632);
        rd_chk(`OFF_GRP_STATE, 32'h00000000, "stopped cont");
        // single scan of group0 ends by itself
        mark = irq_cnt;
        wr(`OFF_SCAN_CTRL, 32'h00003651);
        wait_irq(3000);
        rd_chk(`OFF_GRP_STATE, 32'h00000000, "single idle");
        bus(1'b0, `OFF_CONV_STATE, 32'h00000000);
        check({31'h0, rdat[0]}, 32'h0, "converter idle");
        rd_chk(`OFF_RESULT0, filt(12'h100, W_MINPH, 1'b1), "res0 c");
        // oversampling mode on channel 0, taps dropped after each result
        data_base <= 12'h0c0;
        mark = irq_cnt;
        wr(`OFF_SCAN_CTRL, 32'h00001671);
        wait_irq(3000);
        rd_chk(`OFF_RESULT0, filt(12'h0c0, W_MINPH, 1'b1), "res0 os");
        check({30'h0, conv_channel}, 32'h0, "os channel held");
        wr(`OFF_SCAN_CTRL, 32'h00001672);
        rd_chk(`OFF_GRP_STATE, 32'h00000000, "stopped os");
        print_verdict();
    end
endmodule
